// *** logic/ts_align_pkg.sv ***
// shared constants for the packet alignment and time stamp block
package ts_align_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_GEN_REF_COUNT = 8'h0c;
    localparam logic [7:0] ADDR_RX_CONTROL    = 8'h20;
    localparam logic [7:0] ADDR_RX_STATUS     = 8'h24;
    localparam logic [7:0] ADDR_RX_REF_COUNT  = 8'h28;

    // ************************************************************
    // receive control fields
    // ************************************************************
    localparam int MODE_LSB          = 0;
    localparam int MODE_MSB          = 1;
    localparam int RECV_CTRL_BIT     = 5;
    localparam int STAMP_INSERT_BIT  = 7;
    localparam int CHANNEL_RESET_BIT = 23;
    localparam logic [31:0] RX_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] RX_CONTROL_MASK  = 32'h0080_00a3;

    // ************************************************************
    // receive status fields
    // ************************************************************
    localparam int STAT_IN_PACKET_BIT = 0;
    localparam int STAT_RUNNING_BIT   = 1;
    localparam int STAT_LANE_LSB      = 2;

    // ************************************************************
    // receive modes
    // ************************************************************
    typedef enum logic [1:0]
    {
        MODE_FIXED_SHORT  = 2'd0,
        MODE_FIXED_LONG   = 2'd1,
        MODE_MIXED_LENGTH = 2'd2,
        MODE_UNFRAMED     = 2'd3
    } rx_mode_t;

    // ************************************************************
    // packet format and timing
    // ************************************************************
    localparam logic [7:0] SYNC_BYTE        = 8'h47;
    localparam logic [7:0] PKT_LEN_SHORT    = 8'd188;
    localparam logic [7:0] PKT_LEN_LONG     = 8'd204;
    localparam int         MCLK_KHZ         = 100000;
    localparam int         REF_CLK_KHZ      = 40500;
    localparam int         REF_COUNT_WIDTH  = 32;

endpackage : ts_align_pkg

// *** logic/ref_count_gen.sv ***
// free-running reference counter advanced at a fractional clock rate
`timescale 1ns/1ns
module ref_count_gen
#(
    parameter int REF_KHZ   = ts_align_pkg::REF_CLK_KHZ,
    parameter int MCLK_KHZ  = ts_align_pkg::MCLK_KHZ,
    parameter int WIDTH     = ts_align_pkg::REF_COUNT_WIDTH
)
(
    input  wire logic             mclk,
    input  wire logic             srst,
    output logic                  refTick,
    output logic [WIDTH-1:0]      refCount
);
    import ts_align_pkg::*;

    // ************************************************************
    // phase accumulator
    // ************************************************************
    // 40.5 MHz from 100 MHz is not an integer ratio, so a
    // fractional accumulator spreads the ticks; jitter is one mclk
    localparam logic [17:0] STEP = 18'(REF_KHZ);
    localparam logic [17:0] MODV = 18'(MCLK_KHZ);

    logic [17:0] phase;
    logic [17:0] phaseSum;

    assign phaseSum = phase + STEP;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            phase   <= 18'h0;
            refTick <= 1'b0;
        end
        else if (phaseSum >= MODV)
        begin
            phase   <= phaseSum - MODV;
            refTick <= 1'b1;
        end
        else
        begin
            phase   <= phaseSum;
            refTick <= 1'b0;
        end
    end

    // ************************************************************
    // counter
    // ************************************************************
    // ticking time base
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            refCount <= '0;
        end
        else if (refTick)
        begin
            refCount <= refCount + WIDTH'(1);
        end
    end

endmodule : ref_count_gen

// *** logic/ts_packet_align_timestamp.sv ***
// receive formatter: packet alignment and time stamps toward the dma fifo
`timescale 1ns/1ns
// Operation
// - sync byte lands on word-aligned address
// - start receiving discards until packet start
// - align in fixed short, long, mixed
// - unframed mode passes bytes untouched
// - live mode change accepted, may misalign
// - channel reset drops packets in flight
// - free-running 40.5 MHz reference counter
// - stamp captured, placed before its packet
// - reference count readable by host
// - stamps only when enabled, framed modes
// - stamp four bytes little endian first
// - idle admits nothing, receiving admits packets
// - stamp enable is control bit 7
// - channel reset is control bit 23
module ts_packet_align_timestamp
(
    input  wire logic             mclk,
    input  wire logic             srst,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // transport stream bytes in
    input  wire logic [7:0]       tsByte,
    input  wire logic             tsValid,
    // words toward the receive fifo
    output logic [31:0]           fifoWord,
    output logic                  fifoValid
);
    import ts_align_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    typedef enum logic [0:0]
    {
        ST_HUNT,
        ST_PACKET
    } frame_state_t;

    frame_state_t state;
    frame_state_t next_state;

    logic [31:0]                  rxControl;
    logic [REF_COUNT_WIDTH-1:0]   refCount;
    logic                         running;
    logic                         runningDly;
    logic                         channelReset;
    logic                         stampEnable;
    rx_mode_t                     mode;
    logic                         framed;
    logic [7:0]                   pktCount;
    logic [7:0]                   next_pktCount;
    logic [1:0]                   lane;
    logic [23:0]                  packLow;
    logic                         byteIn;
    logic                         pushByte;
    logic                         pushStamp;
    logic                         atBoundary;
    logic                         isSync;
    logic                         setupPhase;
    logic                         accessWrite;

    // ************************************************************
    // reference counter
    // ************************************************************
    // tick left open: stamps copy the count itself
    ref_count_gen u_ref_count
    (
        .mclk     (mclk),
        .srst     (srst),
        .refTick  (),
        .refCount (refCount)
    );

    // ************************************************************
    // control field decode
    // ************************************************************
    assign mode         = rx_mode_t'(rxControl[MODE_MSB:MODE_LSB]);
    assign running      = rxControl[RECV_CTRL_BIT];
    assign stampEnable  = rxControl[STAMP_INSERT_BIT];
    assign channelReset = rxControl[CHANNEL_RESET_BIT];
    assign framed       = (mode != MODE_UNFRAMED);
    assign isSync       = (tsByte == SYNC_BYTE);
    // the first receiving cycle is skipped as well: the word
    // lanes are cleared in it, so a byte taken there would be lost
    assign byteIn       = tsValid && running && runningDly
                       && !channelReset;

    // ************************************************************
    // apb slave
    // ************************************************************
    // zero wait states: read data is captured in the setup phase
    assign pready      = 1'b1;
    assign setupPhase  = psel && !penable;
    assign accessWrite = psel && penable && pwrite;

    function automatic logic addrKnown(input logic [7:0] a);
        addrKnown = (a == ADDR_GEN_REF_COUNT) || (a == ADDR_RX_CONTROL)
                 || (a == ADDR_RX_STATUS) || (a == ADDR_RX_REF_COUNT);
    endfunction : addrKnown

    // writes to the read-only counts end without an error
    assign pslverr = psel && penable && !addrKnown(paddr);

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rxControl <= RX_CONTROL_RESET;
        end
        else if (accessWrite && paddr == ADDR_RX_CONTROL)
        begin
            // mode writes take effect at once
            rxControl <= pwdata & RX_CONTROL_MASK;
        end
    end

    // ************************************************************
    // register read
    // ************************************************************

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            prdata <= 32'h0;
        end
        else if (setupPhase && !pwrite)
        begin
            if (paddr == ADDR_GEN_REF_COUNT)
            begin
                prdata <= refCount;
            end
            else if (paddr == ADDR_RX_REF_COUNT)
            begin
                prdata <= refCount;
            end
            else if (paddr == ADDR_RX_CONTROL)
            begin
                prdata <= rxControl;
            end
            else if (paddr == ADDR_RX_STATUS)
            begin
                prdata                     <= 32'h0;
                prdata[STAT_IN_PACKET_BIT] <= (state == ST_PACKET);
                prdata[STAT_RUNNING_BIT]   <= running;
                prdata[STAT_LANE_LSB +: 2] <= lane;
            end
            else
            begin
                prdata <= 32'h0;
            end
        end
    end

    // ************************************************************
    // framing decision
    // ************************************************************
    always_comb
    begin
        atBoundary = 1'b0;
        case (mode)
            MODE_FIXED_SHORT:  atBoundary = (pktCount == PKT_LEN_SHORT);
            MODE_FIXED_LONG:   atBoundary = (pktCount == PKT_LEN_LONG);
            // mixed: a sync after 188 bytes ends the packet early
            MODE_MIXED_LENGTH: atBoundary = (pktCount == PKT_LEN_LONG)
                || (pktCount == PKT_LEN_SHORT && isSync);
            default:           atBoundary = 1'b0;
        endcase
    end

    always_comb
    begin
        next_state    = state;
        next_pktCount = pktCount;
        pushByte      = 1'b0;
        pushStamp     = 1'b0;
        if (byteIn)
        begin
            if (!framed)
            begin
                pushByte = 1'b1;
            end
            else
            begin
                case (state)
                    ST_HUNT:
                    begin
                        if (isSync)
                        begin
                            pushByte      = 1'b1;
                            next_pktCount = 8'd1;
                            next_state    = ST_PACKET;
                        end
                    end
                    ST_PACKET:
                    begin
                        if (!atBoundary)
                        begin
                            pushByte      = 1'b1;
                            next_pktCount = pktCount + 8'd1;
                        end
                        else if (isSync)
                        begin
                            pushByte      = 1'b1;
                            next_pktCount = 8'd1;
                        end
                        else
                        begin
                            // lost sync: hunt again rather than misalign
                            next_state    = ST_HUNT;
                            next_pktCount = 8'd0;
                        end
                    end
                    default:
                    begin
                        next_state = ST_HUNT;
                    end
                endcase
                // stamps only in framed modes when enabled
                // stamp placed ahead of its packet
                // a stamp needs a free word, so it is skipped if a
                // live mode change has left the lane misaligned
                pushStamp = pushByte && next_pktCount == 8'd1
                         && stampEnable && lane == 2'd0;
            end
        end
    end

    // ************************************************************
    // frame state
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            runningDly <= 1'b0;
        end
        else
        begin
            runningDly <= running;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state    <= ST_HUNT;
            pktCount <= 8'd0;
        end
        // channel reset drops packets in flight
        else if (channelReset || !running)
        begin
            state    <= ST_HUNT;
            pktCount <= 8'd0;
        end
        else
        begin
            state    <= next_state;
            pktCount <= next_pktCount;
        end
    end

    // ************************************************************
    // word packing toward the fifo
    // ************************************************************
    // packets start on lane zero, and 188, 204 and the stamp
    // are all multiples of four, so every sync stays word aligned
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            lane    <= 2'd0;
            packLow <= 24'h0;
        end
        else if (channelReset || (running && !runningDly))
        begin
            // a fresh start restarts on a word boundary
            lane    <= 2'd0;
            packLow <= 24'h0;
        end
        else if (pushByte)
        begin
            case (lane)
                2'd0:    packLow[7:0]   <= tsByte;
                2'd1:    packLow[15:8]  <= tsByte;
                2'd2:    packLow[23:16] <= tsByte;
                default: packLow        <= packLow;
            endcase
            lane <= lane + 2'd1;
        end
    end

    // no back-pressure: the dma side must take every pulse
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            fifoWord  <= 32'h0;
            fifoValid <= 1'b0;
        end
        else if (pushStamp)
        begin
            // stamp word, low byte first in memory
            // sampled when the sync byte arrives
            // long mode grows to 208 bytes
            fifoWord  <= refCount;
            fifoValid <= 1'b1;
        end
        else if (pushByte && lane == 2'd3)
        begin
            fifoWord  <= {tsByte, packLow};
            fifoValid <= 1'b1;
        end
        else
        begin
            fifoValid <= 1'b0;
        end
    end

endmodule : ts_packet_align_timestamp

// *** dv/ts_source_model.sv ***
// transport stream byte source facing the receive formatter
`timescale 1ns/1ns
module ts_source_model
import ts_align_pkg::*;
(
    input  wire logic       mclk,
    output logic [7:0]      tsByte,
    output logic            tsValid
);
    logic [7:0] log[$];
    int         syncAt[$];
    int         cyc;
    initial
    begin
        tsByte = 8'h00;
        tsValid = 1'b0;
        cyc = 0;
    end
    always @(posedge mclk) cyc <= cyc + 1;
    // one packet, sync first; payload never mimics a sync byte
    task send(input int len, input bit keep);
        logic [7:0] b;
        for (int i = 0; i < len; i++)
        begin
            b = i ? 8'($urandom_range(255)) : SYNC_BYTE;
            if (i != 0 && b == SYNC_BYTE)
                b = 8'h00;
            @(posedge mclk);
            tsByte <= b;
            tsValid <= 1'b1;
            if (keep)
                log.push_back(b);
            if (keep && i == 0)
                syncAt.push_back(cyc);
        end
        // released line shows the inverse, not a stale copy
        @(posedge mclk);
        tsValid <= 1'b0;
        tsByte <= ~b;
        repeat ($urandom_range(2)) @(posedge mclk);
    endtask : send
endmodule : ts_source_model

// *** dv/ts_align_asserts.sv ***
// port checker for the packet alignment block
`timescale 1ns/1ns
module ts_align_asserts
import ts_align_pkg::*;
(
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] fifoWord,
    input wire logic        fifoValid
);
    // ****************
    // control shadow
    // ****************
    logic [31:0] ctl;
    logic        acc;
    logic        mapped;
    assign acc = psel && penable;
    assign mapped = paddr inside {ADDR_GEN_REF_COUNT, ADDR_RX_CONTROL,
                                  ADDR_RX_STATUS, ADDR_RX_REF_COUNT};
    // mirror of writes: tells idle and channel reset apart
    always_ff @(posedge mclk)
    begin
        if (srst)
            ctl <= RX_CONTROL_RESET;
        else if (acc && pwrite && paddr == ADDR_RX_CONTROL)
            ctl <= pwdata & RX_CONTROL_MASK;
    end
    // ****************
    // properties
    // ****************
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_ctl_read;
        psel && !penable && !pwrite && paddr == ADDR_RX_CONTROL ##1 acc;
    endsequence
    sequence s_bad_read;
        psel && !penable && !pwrite && !mapped ##1 acc;
    endsequence
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_err_access: assert property (!acc |-> !pslverr)
        else $error("pslverr outside access");
    a_ctl_readback: assert property (s_ctl_read |-> prdata == ctl)
        else $error("control read mismatch");
    a_bad_zero: assert property (s_bad_read |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property
        (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    a_idle_silent: assert property
        ((!ctl[RECV_CTRL_BIT]) [*3] |-> !fifoValid)
        else $error("output while idle");
    a_chrst_silent: assert property
        (ctl[CHANNEL_RESET_BIT] [*3] |-> !fifoValid)
        else $error("output in channel reset");
    a_word_holds: assert property
        (!fifoValid && !$past(srst) |-> $stable(fifoWord))
        else $error("word changed without pulse");
endmodule : ts_align_asserts
bind ts_packet_align_timestamp ts_align_asserts ts_align_asserts_i
(
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fifoWord(fifoWord),
    .fifoValid(fifoValid)
);

// *** dv/testbench.sv ***
// self-checking bench for the packet alignment block
`timescale 1ns/1ns
module testbench;
import ts_align_pkg::*;
    logic        mclk, srst, psel, penable, pwrite, pready, pslverr, er;
    logic        tsValid, fifoValid;
    logic [7:0]  paddr, tsByte;
    logic [31:0] pwdata, prdata, fifoWord, rd, s;
    int          fails = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    logic [7:0]  outB[$];
    ts_packet_align_timestamp ts_packet_align_timestamp_i
    (
        .mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tsByte(tsByte),
        .tsValid(tsValid), .fifoWord(fifoWord), .fifoValid(fifoValid)
    );
    ts_source_model ts_source_model_i
        (.mclk(mclk), .tsByte(tsByte), .tsValid(tsValid));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ****************
    // capture and watchdog
    // ****************
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (fifoValid === 1'b1)
            for (int k = 0; k < 4; k++)
                outB.push_back(fifoWord[8*k +: 8]);
        if (cyc > 20000)
        begin
            fails++;
            finish_test();
        end
    end
    // ****************
    // helpers
    // ****************
    function int ticks(input int dc);
        return dc * REF_CLK_KHZ / MCLK_KHZ;
    endfunction : ticks
    task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task run(input rx_mode_t m, input logic st);
        logic [31:0] c, sp;
        int          len, o, nL;
        c = 32'(m) | (32'(st) << STAMP_INSERT_BIT);
        len = (m == MODE_FIXED_LONG) ? 204 : 188;
        apb(1'b1, ADDR_RX_CONTROL, 32'h0);
        apb(1'b1, ADDR_RX_CONTROL, 32'h1 << CHANNEL_RESET_BIT);
        apb(1'b1, ADDR_RX_CONTROL, c);
        ts_source_model_i.log.delete();
        ts_source_model_i.syncAt.delete();
        outB.delete();
        // receive switched on in mid-packet in the framed modes; unframed runs send nothing here
        fork
            if (m != MODE_UNFRAMED) ts_source_model_i.send(len, 0);
            begin
                repeat (30) @(posedge mclk);
                apb(1'b1, ADDR_RX_CONTROL, c | (32'h1 << RECV_CTRL_BIT));
            end
        join
        if (m == MODE_UNFRAMED)
            ts_source_model_i.send(2, 1);
        // whole packets only, so every slot keeps its size
        // mixed mode is fed a single length, never a change
        repeat (3) ts_source_model_i.send(len, 1);
        repeat (4) @(posedge mclk);
        if (m == MODE_UNFRAMED)
        begin
            nL = ts_source_model_i.log.size() / 4 * 4;
            check("raw count", outB.size(), nL);
            for (int i = 0; i < nL; i++)
                check("raw byte", outB[i], ts_source_model_i.log[i]);
        end
        else
        begin
            check("count", outB.size(), 3 * (len + 4 * st));
            o = 0;
            for (int p = 0; p < 3; p++)
            begin
                if (st)
                begin
                    s = {outB[o+3], outB[o+2], outB[o+1], outB[o]};
                    nL = ts_source_model_i.syncAt[p] - ts_source_model_i.syncAt[0];
                    if (p > 0)
                        check("stamp", s - sp + 1 - ticks(nL) <= 2, 1);
                    else
                        sp = s;
                    o += 4;
                end
                // sync must sit in the word slot after the stamp
                check("sync lane", outB[o], SYNC_BYTE);
                for (int k = 0; k < len; k++)
                    check("byte", outB[o+k], ts_source_model_i.log[p*len+k]);
                o += len;
            end
        end
        $display("test done mode %0d stamp %0d", m, st);
    endtask : run
    task finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // ****************
    // main sequence
    // ****************
    initial
    begin
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(32'hf8edb201));
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        apb(1'b0, ADDR_RX_CONTROL, 32'h0);
        check("ctl reset", rd, RX_CONTROL_RESET);
        s = $urandom;
        apb(1'b1, ADDR_RX_CONTROL, s);
        apb(1'b0, ADDR_RX_CONTROL, 32'h0);
        check("ctl rw", rd, s & RX_CONTROL_MASK);
        apb(1'b0, ADDR_RX_STATUS, 32'h0);
        check("status", rd, 32'(s[RECV_CTRL_BIT]) << STAT_RUNNING_BIT);
        apb(1'b0, 8'h10, 32'h0);
        check("bad err", er, 1);
        check("bad data", rd, 0);
        // both count addresses show the one counter
        apb(1'b0, ADDR_GEN_REF_COUNT, 32'h0);
        s = rd;
        repeat (1000) @(posedge mclk);
        apb(1'b0, ADDR_RX_REF_COUNT, 32'h0);
        check("ref rate", rd - s + 1 - ticks(1003) <= 2, 1);
        $display("test done registers");
        for (int m = 0; m < 4; m++)
            for (int t = 0; t < 2; t++)
                run(rx_mode_t'(m), t[0]);
        // live switch to unframed mid-packet keeps bytes flowing
        apb(1'b1, ADDR_RX_CONTROL, 32'h0);
        apb(1'b1, ADDR_RX_CONTROL, 32'h1 << RECV_CTRL_BIT);
        outB.delete();
        fork
            ts_source_model_i.send(PKT_LEN_SHORT, 0);
            begin
                repeat (50) @(posedge mclk);
                apb(1'b1, ADDR_RX_CONTROL,
                    (32'h1 << RECV_CTRL_BIT) | 32'(MODE_UNFRAMED));
            end
        join
        repeat (4) @(posedge mclk);
        check("live switch", outB.size(), PKT_LEN_SHORT);
        check("live sync", outB[0], SYNC_BYTE);
        $display("test done live switch");
        // idle, then receive under channel reset: nothing may pass
        for (int j = 0; j < 2; j++)
        begin
            apb(1'b1, ADDR_RX_CONTROL, j ? 32'h0080_0020 : 32'h0);
            outB.delete();
            repeat (2) ts_source_model_i.send(188, 0);
            repeat (2) @(posedge mclk);
            check("blocked", outB.size(), 0);
        end
        $display("test done blocking");
        finish_test();
    end
endmodule : testbench
